// >>> design/rlc_cfg.svh
// Constants for the rotate-left-through-carry execution block
`ifndef RLC_CFG_SVH
`define RLC_CFG_SVH

// ****************************************
// Instruction word layout
// ****************************************
`define RLC_OPCODE         6'h0D
`define RLC_OPC_HI         15
`define RLC_OPC_LO         10
`define RLC_DEST_BIT       9
`define RLC_ACC_BIT        8
`define RLC_F_HI           7
`define RLC_F_LO           0

// ****************************************
// Addressing
// ****************************************
`define RLC_IDX_LIMIT      8'h5F
`define RLC_WIN_LOW_BANK   4'h0
`define RLC_WIN_HIGH_BANK  4'hF

// ****************************************
// Register offsets
// ****************************************
`define RLC_OFF_CTRL       4'h0
`define RLC_OFF_BANK       4'h1
`define RLC_OFF_ACCUM      4'h2
`define RLC_OFF_STATUS     4'h3

// ****************************************
// Field positions and reset values
// ****************************************
`define RLC_CTRL_EXT_BIT   0
`define RLC_ST_C_BIT       0
`define RLC_ST_Z_BIT       2
`define RLC_ST_N_BIT       4
`define RLC_RST_BYTE       8'h00
`define RLC_RST_BANK       4'h0
`define RLC_RST_ADDR       12'h000
`define RLC_RST_INSTR      16'h0000

`endif

// >>> design/rlc_pkg.sv
// Types shared by the rotate-left-through-carry execution block
package rlc_pkg;

  // Instruction cycle phases, idle between instructions
  typedef enum logic [2:0] {
    S_IDLE,
    S_DECODE,
    S_READ,
    S_PROCESS,
    S_WRITE
  } phase_t;

endpackage

// >>> design/rotate_left_through_carry_exec.sv
// Execution datapath for the rotate-left-through-carry byte instruction
// Notes on behaviour
// - Result is operand shifted left; old carry enters bit 0, bit 7 becomes carry.
// - Destination bit 0: result goes to the accumulator, source register untouched.
// - Destination bit 1: result is written back to the source data-memory register.
// - Access bit 0, extended set off or field above 95: operand sits in the fixed access window, bank select ignored.
// - Access bit 1: address is bank select register joined with the register field.
// - Access bit 0, extended set on, field at most 95: indexed literal offset address.
`timescale 1ns/1ps
`default_nettype none
`include "rlc_cfg.svh"

module rotate_left_through_carry_exec
  import rlc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Instruction from the decoder
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr,
  output logic             o_instr_ready,
  output logic             o_busy,
  // Indexed literal offset base pointer
  input  wire logic [11:0] i_index_base,
  // Data memory port
  output logic      [11:0] o_mem_addr,
  output logic             o_mem_rd,
  input  wire logic  [7:0] i_mem_rdata,
  output logic             o_mem_wr,
  output logic       [7:0] o_mem_wdata,
  // Register port
  input  wire logic  [3:0] i_reg_addr,
  input  wire logic  [7:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic       [7:0] o_reg_rdata
);

  // ****************************************
  // Address forming
  // ****************************************

  // Used by decode; kept apart so the access modes read side by side
  function automatic logic [11:0] form_addr(input logic [7:0] f, input logic acc,
                                            input logic ext, input logic [3:0] bank,
                                            input logic [11:0] base);
    logic [11:0] a;
    a = {bank, f};
    if (!acc) begin
      if (ext && (f <= `RLC_IDX_LIMIT)) begin
        a = base + {4'h0, f};
      end else if (f <= `RLC_IDX_LIMIT) begin
        a = {`RLC_WIN_LOW_BANK, f};
      end else begin
        a = {`RLC_WIN_HIGH_BANK, f};
      end
    end
    return a;
  endfunction

  // ****************************************
  // State
  // ****************************************
  phase_t      st_reg,      st_next;
  logic [15:0] instr_reg,   instr_next;
  logic        ext_q_reg,   ext_q_next;
  logic [11:0] addr_reg,    addr_next;
  logic  [7:0] result_reg,  result_next;
  logic        rc_reg,      rc_next;
  logic        rn_reg,      rn_next;
  logic        rz_reg,      rz_next;
  logic        ctrl_ext_reg, ctrl_ext_next;
  logic  [3:0] bank_reg,    bank_next;
  logic  [7:0] accum_reg,   accum_next;
  logic        carry_reg,   carry_next;
  logic        neg_reg,     neg_next;
  logic        zero_reg,    zero_next;
  logic  [7:0] rdata_reg,   rdata_next;
  logic  [7:0] rot_res;
  logic        rot_c;
  logic        rot_n;
  logic        rot_z;
  logic        take;
  logic        dest_bit;
  logic  [7:0] status_rd;

  assign dest_bit = instr_reg[`RLC_DEST_BIT];
  // Only words with the matching opcode are taken; others are left to other units
  assign take = i_instr_valid && (st_reg == S_IDLE) &&
                (i_instr[`RLC_OPC_HI:`RLC_OPC_LO] == `RLC_OPCODE);

  // Strobes straight from the phase
  assign o_instr_ready = (st_reg == S_IDLE);
  assign o_busy        = (st_reg != S_IDLE);
  assign o_mem_rd      = (st_reg == S_READ);
  assign o_mem_wr      = (st_reg == S_WRITE) && dest_bit;
  assign o_mem_addr    = addr_reg;
  assign o_mem_wdata   = result_reg;
  assign o_reg_rdata   = rdata_reg;

  // Rotator sees the memory byte directly, so the result is ready for the write phase
  rotate_unit u_rot (
    .i_data   (i_mem_rdata),
    .i_carry  (carry_reg),
    .o_result (rot_res),
    .o_carry  (rot_c),
    .o_neg    (rot_n),
    .o_zero   (rot_z)
  );

  // ****************************************
  // Phase sequencer and datapath
  // ****************************************

  // Mode bit is caught at accept so software cannot change it mid-instruction
  always_comb begin
    st_next      = st_reg;
    instr_next   = instr_reg;
    ext_q_next   = ext_q_reg;
    addr_next    = addr_reg;
    result_next  = result_reg;
    rc_next      = rc_reg;
    rn_next      = rn_reg;
    rz_next      = rz_reg;
    unique case (st_reg)
      S_IDLE: begin
        if (take) begin
          instr_next = i_instr;
          ext_q_next = ctrl_ext_reg;
          st_next    = S_DECODE;
        end
      end
      S_DECODE: begin
        addr_next = form_addr(instr_reg[`RLC_F_HI:`RLC_F_LO], instr_reg[`RLC_ACC_BIT],
                              ext_q_reg, bank_reg, i_index_base);
        st_next   = S_READ;
      end
      S_READ: begin
        st_next = S_PROCESS;
      end
      S_PROCESS: begin
        // Memory answers one cycle after the read strobe; result and flags caught here
        result_next = rot_res;
        rc_next     = rot_c;
        rn_next     = rot_n;
        rz_next     = rot_z;
        st_next     = S_WRITE;
      end
      S_WRITE: begin
        st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg      <= S_IDLE;
      instr_reg   <= `RLC_RST_INSTR;
      ext_q_reg   <= 1'b0;
      addr_reg    <= `RLC_RST_ADDR;
      result_reg  <= `RLC_RST_BYTE;
      rc_reg      <= 1'b0;
      rn_reg      <= 1'b0;
      rz_reg      <= 1'b0;
    end else begin
      st_reg      <= st_next;
      instr_reg   <= instr_next;
      ext_q_reg   <= ext_q_next;
      addr_reg    <= addr_next;
      result_reg  <= result_next;
      rc_reg      <= rc_next;
      rn_reg      <= rn_next;
      rz_reg      <= rz_next;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  assign status_rd = 8'h00 | ({7'h00, carry_reg} << `RLC_ST_C_BIT)
                           | ({7'h00, zero_reg} << `RLC_ST_Z_BIT)
                           | ({7'h00, neg_reg} << `RLC_ST_N_BIT);

  // Commit in the write phase beats a software write in the same cycle
  always_comb begin
    ctrl_ext_next = ctrl_ext_reg;
    bank_next     = bank_reg;
    accum_next    = accum_reg;
    carry_next    = carry_reg;
    neg_next      = neg_reg;
    zero_next     = zero_reg;
    rdata_next    = 8'h00;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `RLC_OFF_CTRL:   ctrl_ext_next = i_reg_wdata[`RLC_CTRL_EXT_BIT];
        `RLC_OFF_BANK:   bank_next     = i_reg_wdata[3:0];
        `RLC_OFF_ACCUM:  accum_next    = i_reg_wdata;
        `RLC_OFF_STATUS: begin
          carry_next = i_reg_wdata[`RLC_ST_C_BIT];
          zero_next  = i_reg_wdata[`RLC_ST_Z_BIT];
          neg_next   = i_reg_wdata[`RLC_ST_N_BIT];
        end
        default: ;
      endcase
    end
    if (st_reg == S_WRITE) begin
      carry_next = rc_reg;
      neg_next   = rn_reg;
      zero_next  = rz_reg;
      if (!dest_bit) begin
        accum_next = result_reg;
      end
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `RLC_OFF_CTRL:   rdata_next = {7'h00, ctrl_ext_reg};
        `RLC_OFF_BANK:   rdata_next = {4'h0, bank_reg};
        `RLC_OFF_ACCUM:  rdata_next = accum_reg;
        `RLC_OFF_STATUS: rdata_next = status_rd;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_ext_reg <= 1'b0;
      bank_reg     <= `RLC_RST_BANK;
      accum_reg    <= `RLC_RST_BYTE;
      carry_reg    <= 1'b0;
      neg_reg      <= 1'b0;
      zero_reg     <= 1'b0;
      rdata_reg    <= `RLC_RST_BYTE;
    end else begin
      ctrl_ext_reg <= ctrl_ext_next;
      bank_reg     <= bank_next;
      accum_reg    <= accum_next;
      carry_reg    <= carry_next;
      neg_reg      <= neg_next;
      zero_reg     <= zero_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [7:0] rd_q;
  logic [7:0] f_fld;
  always_ff @(posedge i_clk) begin
    rd_q <= i_mem_rdata;
  end
  assign f_fld = instr_reg[`RLC_F_HI:`RLC_F_LO];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_rot_result: assert property ((st_reg == S_WRITE) |-> result_reg == {rd_q[6:0], carry_reg})
    else $error("rotated result wrong");
  a_carry_out: assert property ((st_reg == S_WRITE) |=> carry_reg == $past(rd_q[7]))
    else $error("carry not taken from bit 7");
  a_dest_accum: assert property ((st_reg == S_WRITE && !dest_bit) |-> !o_mem_wr ##1 accum_reg == $past(result_reg))
    else $error("accumulator destination wrong");
  a_dest_mem: assert property ((st_reg == S_WRITE && dest_bit) |-> o_mem_wr && o_mem_wdata == {rd_q[6:0], carry_reg})
    else $error("memory write back wrong");
  a_access_win: assert property ((st_reg == S_READ && !instr_reg[`RLC_ACC_BIT] && !(ext_q_reg && f_fld <= `RLC_IDX_LIMIT))
      |-> o_mem_addr == {((f_fld <= `RLC_IDX_LIMIT) ? `RLC_WIN_LOW_BANK : `RLC_WIN_HIGH_BANK), f_fld})
    else $error("access window address wrong");
  a_bank_addr: assert property ((st_reg == S_READ && instr_reg[`RLC_ACC_BIT]) |-> o_mem_addr == {$past(bank_reg), f_fld})
    else $error("banked address wrong");
  a_index_addr: assert property ((st_reg == S_READ && !instr_reg[`RLC_ACC_BIT] && ext_q_reg && f_fld <= `RLC_IDX_LIMIT)
      |-> o_mem_addr == $past(i_index_base) + {4'h0, f_fld})
    else $error("indexed address wrong");
  a_phase_seq: assert property (take |=> st_reg == S_DECODE ##1 o_mem_rd ##1 st_reg == S_PROCESS
      ##1 st_reg == S_WRITE ##1 o_instr_ready)
    else $error("phase sequence wrong");

  c_to_accum: cover property ((st_reg == S_WRITE) && !dest_bit);
  c_to_mem:   cover property (o_mem_wr);
  c_indexed:  cover property ((st_reg == S_READ) && !instr_reg[`RLC_ACC_BIT] && ext_q_reg && f_fld <= `RLC_IDX_LIMIT);
  c_carry_in: cover property ((st_reg == S_WRITE) && carry_reg && rd_q[7]);

endmodule

`default_nettype wire

// >>> design/rotate_unit.sv
// Combinational rotate of one byte through the carry, with result flags
`timescale 1ns/1ps
`default_nettype none

module rotate_unit (
  // Operand
  input  wire logic [7:0] i_data,
  input  wire logic       i_carry,
  // Result
  output logic      [7:0] o_result,
  output logic            o_carry,
  output logic            o_neg,
  output logic            o_zero
);

  // Old carry enters bit 0, old bit 7 leaves as carry
  always_comb begin
    o_result = {i_data[6:0], i_carry};
    o_carry  = i_data[7];
    o_neg    = o_result[7];
    o_zero   = (o_result == 8'h00);
  end

endmodule

`default_nettype wire

// >>> test/data_mem_model.sv
// Behavioural data memory standing behind the execution block's memory port
`timescale 1ns/1ps
`default_nettype none

module data_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Memory port from the block
  input  wire logic [11:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic  [7:0] i_wdata,
  output logic       [7:0] o_rdata
);
  logic [7:0] mem [0:4095];

  // Read data holds for one cycle only, then toggles so that stale data never looks valid
  // Plain always, since the bench preloads the array from outside this process
  always @(posedge i_clk) begin
    if (i_rd) begin
      o_rdata <= mem[i_addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the rotate-left-through-carry execution block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        i_clk         = 1'b0;
  logic        i_rst         = 1'b1;
  logic        i_instr_valid = 1'b0;
  logic [15:0] i_instr       = 16'h0000;
  logic [11:0] i_index_base  = 12'h120;
  logic [3:0]  i_reg_addr    = 4'h0;
  logic [7:0]  i_reg_wdata   = 8'h00;
  logic        i_reg_wr      = 1'b0;
  logic        i_reg_rd      = 1'b0;
  logic        o_instr_ready;
  logic        o_busy;
  logic        o_mem_rd;
  logic        o_mem_wr;
  logic [11:0] o_mem_addr;
  logic [7:0]  o_mem_wdata;
  logic [7:0]  i_mem_rdata;
  logic [7:0]  o_reg_rdata;
  logic        cy;
  int          n_errors      = 0;
  int          checks_done   = 0;
  int          cyc           = 0;

  rotate_left_through_carry_exec u_rotate_left_through_carry_exec (
    .i_clk(i_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .o_instr_ready(o_instr_ready), .o_busy(o_busy), .i_index_base(i_index_base),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata)
  );

  data_mem_model u_data_mem_model (
    .i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata)
  );

  // Free-running 25 MHz clock
  always #20 i_clk = ~i_clk;

  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Widened to 12 bits so one compare serves addresses and bytes
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr    <= 1'b0;
  endtask

  // Read data is looked at in the single cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd   <= 1'b0;
    #1;
    check("reg_rdata", {4'h0, o_reg_rdata}, {4'h0, exp});
  endtask

  // One instruction: preload operand, issue, check address, timing, result and flags
  task automatic run(input logic d, input logic a, input logic [7:0] f, input logic [7:0] v,
                     input logic [11:0] ea);
    logic [7:0] r;
    int         k;
    r = {v[6:0], cy};
    u_data_mem_model.mem[ea] = v;
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= {6'h0D, d, a, f};
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_mem_rd !== 1'b1 && k < 8);
    check("read_cycle", 12'(k), 12'h001);
    check("mem_addr", o_mem_addr, ea);
    k = 0;
    while (o_instr_ready !== 1'b1 && k < 8) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check("ready_again", 12'(k), 12'h003);
    check("mem_byte", {4'h0, u_data_mem_model.mem[ea]}, {4'h0, d ? r : v});
    cy = v[7];
    if (!d) begin
      reg_rd(4'h2, r);
    end
    reg_rd(4'h3, {3'b000, r[7], 1'b0, r == 8'h00, 1'b0, cy});
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    cy = 1'b0;
    // Reset values, unmapped places read as zero
    for (int i = 0; i < 8; i++) begin
      reg_rd(4'(i), 8'h00);
    end
    reg_wr(4'h3, 8'h01);
    cy = 1'b1;
    reg_wr(4'h1, 8'h05);
    run(1'b1, 1'b1, 8'hA3, 8'h81, 12'h5A3);
    run(1'b0, 1'b0, 8'h10, 8'h40, 12'h010);
    run(1'b1, 1'b0, 8'h80, 8'h80, 12'hF80);
    reg_wr(4'h0, 8'h01);
    run(1'b1, 1'b0, 8'h5F, 8'h7E, 12'h17F);
    run(1'b1, 1'b0, 8'h60, 8'h01, 12'hF60);
    run(1'b1, 1'b1, 8'h00, 8'hFF, 12'h500);
    i_index_base <= 12'hFF0;
    run(1'b0, 1'b0, 8'h20, 8'h33, 12'h010);
    // Foreign opcode offered for several cycles must be ignored
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= 16'h3000;
    repeat (3) begin
      @(posedge i_clk);
      #1;
      check("foreign_busy", {11'h000, o_busy | o_mem_rd}, 12'h000);
    end
    i_instr_valid <= 1'b0;
    give_verdict();
  end
endmodule

`default_nettype wire
